// file: hw/fcm_pkg.sv
// Functional notes
// - monitor register reads the committed shadow copy, not the staged value
// - command-enable monitor bit is one only when 101 is committed
// - monitor bits 7 and 6 always read zero
// - in serial programming mode loader map monitor reads one
// - standby bit writes accepted only from ram-resident code
// - flash access while standby bit set raises a standby reset
// - standby register reads zero on all bits
// - serial clock enable gates clock pin; general enable gates other ports
// - in controller mode port-input register ignored, writes dropped, reads zero
// - stage 101 to enable, 010 to disable, then commit key D5
// - commands and toggles ignored while command execution disabled
// - command-enable field resets to 010
// - disabling rejects later commands but does not abort a running one
// - memory transfers reach flash only through the data area
// - committed area select 10 maps code upper half onto data upper half
// - ram map field with key D4 maps ram into code area
// - serial programming mode always maps ram into code area
// - committed loader map one overlays 1000-17FF with loader rom
// - serial mode maps loader rom data 1000-17FF, code 1000-1FFF
// - serial mode forces loader map to one; field writes are still staged and committed
// - staged register takes effect only on commit key D5
`default_nettype none
package fcm_pkg;
  localparam logic [11:0] STAGED_OFS  = 12'hFD0;
  localparam logic [11:0] MONITOR_OFS = 12'hFD1;
  localparam logic [11:0] COMMIT_OFS  = 12'hFD1;
  localparam logic [11:0] STANDBY_OFS = 12'hFD2;
  localparam logic [11:0] PORTIN_OFS  = 12'hFD3;
  localparam logic [11:0] SYSMAP_OFS  = 12'hFD4;
  localparam logic [11:0] SYSCOM_OFS  = 12'hFD5;
  localparam logic [11:0] STATUS_OFS  = 12'hFD6;
  localparam logic [7:0]  CR1_KEY     = 8'hD5;
  localparam logic [7:0]  SYS_KEY     = 8'hD4;
  localparam logic [2:0]  CMD_ON      = 3'h5;
  localparam logic [2:0]  CMD_OFF     = 3'h2;
  localparam logic [1:0]  AREA_STD    = 2'h0;
  localparam logic [1:0]  AREA_CODE   = 2'h2;
  localparam logic [7:0]  STAGED_RST  = 8'h40;
  localparam logic [7:0]  PORTIN_RST  = 8'h80;
  localparam int          CMD_LSB     = 5;
  localparam int          LDR_BIT     = 4;
  localparam int          AREA_LSB    = 2;
  localparam logic [15:0] LDR_LO      = 16'h1000;
  localparam logic [15:0] LDR_DHI     = 16'h17FF;
  localparam logic [15:0] LDR_CHI     = 16'h1FFF;
  localparam logic [15:0] UPPER_LO    = 16'h8000;
endpackage
`default_nettype wire

// file: hw/fcm_flash_ctrl.sv
`default_nettype none
module fcm_flash_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_mode_pin,
  input  wire logic        exec_from_ram,
  input  wire logic        flash_access,
  input  wire logic        flash_cmd_req,
  input  wire logic        flash_busy,
  output logic             flash_cmd_ok,
  output logic             standby_reset,
  output logic             general_input_enable,
  output logic             serial_clock_input_enable,
  output logic             cmd_enabled,
  output logic             code_upper_to_data,
  output logic             ram_in_code,
  output logic             loader_rom_data,
  output logic             loader_rom_code_ext
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sm;
    logic [7:0] staged;
    logic [7:0] shadow;
    logic       stby;
    logic [1:0] pin;
    logic       ram_fld;
    logic       ram_map;
    logic [31:0] rdata;
    logic       ready;
    logic       err;
    logic       cmd_ok;
    logic       sreset;
    logic       serial;
    logic [6:0] outs;
  } fcm_state_t;

  fcm_state_t  st_r;
  fcm_state_t  st_nxt;
  logic        serial;
  logic        access;
  logic        commit;
  logic [11:0] ofs;

  // address decode shared by the error flag of reads and writes
  function automatic logic fcm_mapped(input logic [11:0] o, input logic w);
    if (w) begin
      return o inside {fcm_pkg::STAGED_OFS, fcm_pkg::COMMIT_OFS, fcm_pkg::STANDBY_OFS,
                       fcm_pkg::PORTIN_OFS, fcm_pkg::SYSMAP_OFS, fcm_pkg::SYSCOM_OFS};
    end
    return o inside {fcm_pkg::STAGED_OFS, fcm_pkg::MONITOR_OFS, fcm_pkg::STANDBY_OFS,
                     fcm_pkg::PORTIN_OFS, fcm_pkg::SYSMAP_OFS, fcm_pkg::STATUS_OFS};
  endfunction

  assign serial = st_r.serial;
  assign ofs    = paddr[13:2];
  // first access cycle answers; the write lands at the edge that sees pready high
  assign access = psel & penable & ~st_r.ready;
  assign commit = psel & penable & pwrite & st_r.ready & ~st_r.err;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.sm     = {st_r.sm[1:0], serial_mode_pin};
    if (st_r.sm[2] == st_r.sm[1]) begin
      st_nxt.serial = st_r.sm[2];
    end
    st_nxt.ready  = access;
    st_nxt.err    = access & ((paddr[1:0] != 2'h0) | ~fcm_mapped(ofs, pwrite));
    st_nxt.rdata  = 32'h0000_0000;
    if (commit) begin
      case (ofs)
        fcm_pkg::STAGED_OFS:  st_nxt.staged = pwdata[7:0];
        fcm_pkg::COMMIT_OFS: begin
          if (pwdata[7:0] == fcm_pkg::CR1_KEY) begin
            st_nxt.shadow = st_r.staged;
          end
        end
        fcm_pkg::STANDBY_OFS: begin
          if (exec_from_ram) begin
            st_nxt.stby = pwdata[0];
          end
        end
        fcm_pkg::PORTIN_OFS: begin
          if (serial) begin
            st_nxt.pin = pwdata[1:0];
          end
        end
        fcm_pkg::SYSMAP_OFS:  st_nxt.ram_fld = pwdata[0];
        fcm_pkg::SYSCOM_OFS: begin
          if (pwdata[7:0] == fcm_pkg::SYS_KEY) begin
            st_nxt.ram_map = st_r.ram_fld;
          end
        end
        default: ;
      endcase
    end
    if (access && !pwrite) begin
      case (ofs)
        fcm_pkg::STAGED_OFS:  st_nxt.rdata = {24'h000000, st_r.staged};
        fcm_pkg::MONITOR_OFS: begin
          st_nxt.rdata = {24'h000000, 2'h0, st_r.shadow[5:0]};
          st_nxt.rdata[7] = 1'b0;
          st_nxt.rdata[fcm_pkg::CMD_LSB+:3] =
            {2'h0, st_r.shadow[fcm_pkg::CMD_LSB+:3] == fcm_pkg::CMD_ON};
          if (serial) begin
            st_nxt.rdata[fcm_pkg::LDR_BIT] = 1'b1;
          end
        end
        fcm_pkg::STANDBY_OFS: st_nxt.rdata = 32'h0000_0000;
        fcm_pkg::PORTIN_OFS:
          st_nxt.rdata = serial ? {24'h000000, fcm_pkg::PORTIN_RST[7:2], st_r.pin}
                                : 32'h0000_0000;
        fcm_pkg::SYSMAP_OFS:  st_nxt.rdata = {31'h0, st_r.ram_fld};
        fcm_pkg::STATUS_OFS:  st_nxt.rdata = {31'h0, st_r.stby};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // commands pass only when enabled; a running one is not aborted
    st_nxt.cmd_ok = flash_cmd_req &
                    (st_r.shadow[fcm_pkg::CMD_LSB+:3] == fcm_pkg::CMD_ON) |
                    flash_busy & st_r.cmd_ok;
    st_nxt.sreset = st_r.stby & flash_access;
    st_nxt.outs[0] = ~serial | st_r.pin[0];
    st_nxt.outs[1] = ~serial | st_r.pin[1];
    st_nxt.outs[2] = st_r.shadow[fcm_pkg::CMD_LSB+:3] == fcm_pkg::CMD_ON;
    st_nxt.outs[3] = st_r.shadow[fcm_pkg::AREA_LSB+:2] == fcm_pkg::AREA_CODE;
    st_nxt.outs[4] = serial | st_r.ram_map;
    st_nxt.outs[5] = serial | st_r.shadow[fcm_pkg::LDR_BIT];
    st_nxt.outs[6] = serial;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= '0;
      st_r.staged <= fcm_pkg::STAGED_RST;
      st_r.shadow <= fcm_pkg::STAGED_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata                    = st_r.rdata;
  assign pready                    = st_r.ready;
  assign pslverr                   = st_r.err;
  assign flash_cmd_ok              = st_r.cmd_ok;
  assign standby_reset             = st_r.sreset;
  assign general_input_enable      = st_r.outs[0];
  assign serial_clock_input_enable = st_r.outs[1];
  assign cmd_enabled               = st_r.outs[2];
  assign code_upper_to_data        = st_r.outs[3];
  assign ram_in_code               = st_r.outs[4];
  assign loader_rom_data           = st_r.outs[5];
  assign loader_rom_code_ext       = st_r.outs[6];
endmodule
`default_nettype wire

// file: tb/fcm_flash_model.sv
`default_nettype none
module fcm_flash_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic flash_cmd_req,
  input  wire logic flash_cmd_ok,
  output logic      flash_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  // a sequence starts only when passed and then runs to its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 4'h0;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    else if (flash_cmd_req && flash_cmd_ok) cnt_r <= 4'hF;
  end
  assign flash_busy = (cnt_r != 4'h0);
endmodule
`default_nettype wire

// file: tb/fcm_chk.sv
`default_nettype none
module fcm_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flash_cmd_req,
  input wire logic flash_busy,
  input wire logic flash_cmd_ok,
  input wire logic cmd_enabled,
  input wire logic flash_access,
  input wire logic standby_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  AST_RDY: assert property (acc_s |=> pready)
    else $error("ready late");
  AST_PUL: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_SRC: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_OFF: assert property ((!cmd_enabled && !flash_busy) [*2] |-> !flash_cmd_ok)
    else $error("command passed while disabled");
  AST_ON: assert property ((cmd_enabled && flash_cmd_req) [*2] |-> flash_cmd_ok)
    else $error("command refused while enabled");
  AST_HLD: assert property (flash_busy [*2] |-> flash_cmd_ok)
    else $error("running sequence dropped");
  AST_STB: assert property (standby_reset |-> $past(flash_access))
    else $error("standby reset without access");
endmodule
bind fcm_flash_ctrl fcm_chk u_fcm_chk (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .flash_cmd_req, .flash_busy, .flash_cmd_ok, .cmd_enabled, .flash_access,
  .standby_reset);
`default_nettype wire

// file: tb/test_flash_control_and_map.sv
`default_nettype none
module test_flash_control_and_map;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, seen = 0, er;
  logic serial_mode_pin = 0, exec_from_ram = 0, flash_access = 0, flash_cmd_req = 0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, flash_busy, flash_cmd_ok, standby_reset, general_input_enable;
  logic serial_clock_input_enable, cmd_enabled, code_upper_to_data, ram_in_code;
  logic loader_rom_data, loader_rom_code_ext;
  int fails = 0, total_checks = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (standby_reset === 1'b1) seen <= 1'b1;
  fcm_flash_ctrl u_fcm_flash_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_mode_pin, .exec_from_ram, .flash_access,
    .flash_cmd_req, .flash_busy, .flash_cmd_ok, .standby_reset, .general_input_enable,
    .serial_clock_input_enable, .cmd_enabled, .code_upper_to_data, .ram_in_code,
    .loader_rom_data, .loader_rom_code_ext);
  fcm_flash_model u_fcm_flash_model (.pclk, .presetn, .flash_cmd_req, .flash_cmd_ok,
    .flash_busy);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc(12'hFD1, 8'h00);
    wr(12'hFD0, 8'hA8);
    rdc(12'hFD1, 8'h00);
    wr(12'hFD1, 8'hD5);
    rdc(12'hFD1, 8'h28);
    chk(32'({cmd_enabled, code_upper_to_data}), 32'h3);
    flash_cmd_req <= 1'b1;
    repeat (3) @(posedge pclk);
    flash_cmd_req <= 1'b0;
    @(posedge pclk);
    chk(32'(flash_busy), 32'h1);
    wr(12'hFD0, 8'h50);
    wr(12'hFD1, 8'hD5);
    repeat (12) @(posedge pclk);
    flash_cmd_req <= 1'b1;
    repeat (4) @(posedge pclk);
    flash_cmd_req <= 1'b0;
    chk(32'(flash_busy), 32'h0);
    rdc(12'hFD1, 8'h10);
    chk(32'(loader_rom_data), 32'h1);
    wr(12'hFD0, 8'h40);
    wr(12'hFD1, 8'hD5);
    wr(12'hFD2, 8'h01);
    flash_access <= 1'b1;
    repeat (3) @(posedge pclk);
    flash_access <= 1'b0;
    chk(32'(seen), 32'h0);
    exec_from_ram <= 1'b1;
    wr(12'hFD2, 8'h01);
    exec_from_ram <= 1'b0;
    rdc(12'hFD2, 8'h00);
    flash_access <= 1'b1;
    repeat (3) @(posedge pclk);
    flash_access <= 1'b0;
    chk(32'(seen), 32'h1);
    exec_from_ram <= 1'b1;
    wr(12'hFD2, 8'h00);
    exec_from_ram <= 1'b0;
    wr(12'hFD3, 8'h03);
    rdc(12'hFD3, 8'h00);
    chk(32'(general_input_enable), 32'h1);
    for (int v = 1; v >= 0; v--) begin
      wr(12'hFD4, 8'(v));
      wr(12'hFD5, 8'hD4);
      repeat (2) @(posedge pclk);
      chk(32'(ram_in_code), 32'(v));
    end
    rdc(12'hFFF, 8'h00);
    chk(32'(er), 32'h1);
    serial_mode_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    rdc(12'hFD1, 8'h10);
    chk(32'({ram_in_code, loader_rom_data, loader_rom_code_ext}), 32'h7);
    rdc(12'hFD3, 8'h80);
    wr(12'hFD3, 8'h03);
    rdc(12'hFD3, 8'h83);
    chk(32'({general_input_enable, serial_clock_input_enable}), 32'h3);
    stop_test();
  end
endmodule
`default_nettype wire
